// ===== rtl/pixel_address_mapper.sv
// Pixel address mapper: readout quad records, pixel-pair configuration addressing, upset-tolerant control
//
// Contract
// - Record address: column, row, region fields
// - Four 4-bit counts follow, left-most first
// - Column register: column, region bit, pair
// - Row register: row, upper three region bits
// - Configuration writes address 17-bit pixel pair
// - Global configuration in triple redundant storage
// - Hits kept unprotected, at most 20 us until the address word is sent
// - Control state triplicated and pause input deglitched
// - Pixel configuration held in plain storage
`timescale 1ns/1ps
`include "pam_cfg.svh"
module pixel_address_mapper import pam_pkg::*; #(
  parameter int HOLD_CYCLES = `HIT_HOLD_CYCLES
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [`PAM_ADDR_W-1:0] addr_in,
  input wire logic [`PAM_DATA_W-1:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output logic [`PAM_DATA_W-1:0] rd_data_out,
  input wire logic hit_valid_in,
  input wire logic [5:0] hit_col_in,
  input wire logic [5:0] hit_row_in,
  input wire logic [3:0] hit_region_in,
  input wire logic [15:0] hit_count_in,
  output logic hit_ready_out,
  input wire logic pause_in,
  output logic rec_valid_out,
  output logic [15:0] rec_data_out,
  output logic rec_last_out,
  input wire logic rec_ready_in,
  output logic [16:0] pix_addr_out,
  output logic [7:0] pix_data_out,
  output logic pix_wr_out,
  output logic upset_out
);

  // ----------------------------------------
  // Global configuration storage
  // ----------------------------------------
  logic [7:0] cpa_q;
  logic [8:0] row_q;
  logic [0:0] ctrl_q;
  logic cpa_upset;
  logic row_upset;
  logic ctrl_upset;
  logic state_upset;
  logic pause_f;
  rd_state_t state_q;
  rd_state_t state_next;
  logic [2:0] state_bits;
  pam_state_t s_reg;
  pam_state_t s_next;

  tmr_reg #(
    .W(8),
    .RST(`CPA_RST)
  ) u_cpa (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .load_in(wr_en_in && (addr_in == `CPA_OFS)),
    .d_in(wr_data_in[7:0]),
    .q_out(cpa_q),
    .upset_out(cpa_upset)
  );

  tmr_reg #(
    .W(9),
    .RST(`ROW_RST)
  ) u_row (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .load_in(wr_en_in && (addr_in == `ROW_OFS)),
    .d_in(wr_data_in[8:0]),
    .q_out(row_q),
    .upset_out(row_upset)
  );

  tmr_reg #(
    .W(1),
    .RST(`CTRL_RST)
  ) u_ctrl (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .load_in(wr_en_in && (addr_in == `CTRL_OFS)),
    .d_in(wr_data_in[`CTRL_EN_BIT]),
    .q_out(ctrl_q),
    .upset_out(ctrl_upset)
  );

  // ----------------------------------------
  // Protected control path
  // ----------------------------------------
  tmr_reg #(
    .W(3),
    .RST(ST_IDLE)
  ) u_state (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .load_in(1'b1),
    .d_in(state_next),
    .q_out(state_bits),
    .upset_out(state_upset)
  );

  deglitch #(
    .N(`DEGLITCH_N)
  ) u_pause (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .sig_in(pause_in),
    .sig_out(pause_f)
  );

  assign state_q = rd_state_t'(state_bits);

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    s_next = s_reg;
    state_next = state_q;
    s_next.pix_wr = 1'b0;
    s_next.rd_data = '0;

    // Register reads answer one cycle later; unmapped reads give zero
    if (rd_en_in) begin
      case (addr_in)
        `CPA_OFS: begin
          s_next.rd_data = {8'h00, cpa_q};
        end
        `ROW_OFS: begin
          s_next.rd_data = {7'h00, row_q};
        end
        `CTRL_OFS: begin
          s_next.rd_data = {15'h0000, ctrl_q};
        end
        `PIXDATA_OFS: begin
          s_next.rd_data = {8'h00, s_reg.pix_data};
        end
        `STATUS_OFS: begin
          s_next.rd_data = 16'h0000;
          s_next.rd_data[`STATUS_BUSY_BIT] = (state_q != ST_IDLE);
          s_next.rd_data[`STATUS_HELD_BIT] = s_reg.hold_valid;
          s_next.rd_data[`STATUS_UPSET_BIT] = s_reg.upset;
        end
        `DROPS_OFS: begin
          s_next.rd_data = {8'h00, s_reg.drop_cnt};
        end
        default: begin
          s_next.rd_data = '0;
        end
      endcase
    end

    // Pixel configuration goes straight to plain latches in the matrix
    if (wr_en_in && (addr_in == `PIXDATA_OFS)) begin
      s_next.pix_addr = {cpa_q[`CPA_COL_MSB:`CPA_COL_LSB],
                         row_q[`ROW_ROW_MSB:`ROW_ROW_LSB],
                         row_q[`ROW_REGION_MSB:`ROW_REGION_LSB],
                         cpa_q[`CPA_REGION_BIT],
                         cpa_q[`CPA_PAIR_BIT]};
      s_next.pix_data = wr_data_in[7:0];
      s_next.pix_wr = 1'b1;
    end

    // Upset flag: a new upset wins over a software clear
    if (wr_en_in && (addr_in == `STATUS_OFS) && wr_data_in[`STATUS_UPSET_BIT]) begin
      s_next.upset = 1'b0;
    end
    if (cpa_upset || row_upset || ctrl_upset || state_upset) begin
      s_next.upset = 1'b1;
    end

    // Software may also clear the drop counter
    if (wr_en_in && (addr_in == `DROPS_OFS)) begin
      s_next.drop_cnt = 8'h00;
    end

    // Hit store ages while its address is still unsent
    if (s_reg.hold_valid && (state_q != ST_COUNT) && (s_reg.age != 13'(HOLD_CYCLES))) begin
      s_next.age = s_reg.age + 13'h0001;
    end

    // Record emitter
    case (state_q)
      ST_IDLE: begin
        s_next.rec_valid = 1'b0;
        s_next.rec_last = 1'b0;
        if (s_reg.hold_valid) begin
          s_next.rec_valid = 1'b1;
          s_next.rec_data = s_reg.hold_addr;
          state_next = ST_ADDR;
        end
      end
      ST_ADDR: begin
        if (rec_ready_in) begin
          s_next.rec_data = s_reg.hold_count;
          s_next.rec_last = 1'b1;
          state_next = ST_COUNT;
        end else if (s_reg.age >= 13'(HOLD_CYCLES)) begin
          s_next.rec_valid = 1'b0;
          s_next.hold_valid = 1'b0;
          if (s_reg.drop_cnt != 8'hff) begin
            s_next.drop_cnt = s_reg.drop_cnt + 8'h01;
          end
          state_next = ST_IDLE;
        end
      end
      ST_COUNT: begin
        if (rec_ready_in) begin
          s_next.rec_valid = 1'b0;
          s_next.rec_last = 1'b0;
          s_next.hold_valid = 1'b0;
          state_next = ST_IDLE;
        end
      end
      default: begin
        s_next.rec_valid = 1'b0;
        s_next.rec_last = 1'b0;
        s_next.hold_valid = 1'b0;
        state_next = ST_IDLE;
      end
    endcase

    // Hit capture into unprotected storage; only taken when the store is empty
    if (hit_valid_in && s_reg.hit_ready) begin
      s_next.hold_valid = 1'b1;
      s_next.hold_addr = {hit_col_in, hit_row_in, hit_region_in};
      s_next.hold_count = hit_count_in;
      s_next.age = 13'h0000;
    end

    s_next.hit_ready = !s_next.hold_valid && ctrl_q[0] && !pause_f;
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rd_data_out = s_reg.rd_data;
  assign hit_ready_out = s_reg.hit_ready;
  assign rec_valid_out = s_reg.rec_valid;
  assign rec_data_out = s_reg.rec_data;
  assign rec_last_out = s_reg.rec_last;
  assign pix_addr_out = s_reg.pix_addr;
  assign pix_data_out = s_reg.pix_data;
  assign pix_wr_out = s_reg.pix_wr;
  assign upset_out = s_reg.upset;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_record_address: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    (hit_valid_in && hit_ready_out) |-> ##2
    (rec_valid_out && !rec_last_out &&
     rec_data_out == {$past(hit_col_in, 2), $past(hit_row_in, 2), $past(hit_region_in, 2)}))
    else $error("record address fields misplaced");

  a_count_word: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    (rec_valid_out && !rec_last_out && rec_ready_in) |=>
    (rec_valid_out && rec_last_out && rec_data_out == s_reg.hold_count))
    else $error("count word did not follow address");

  a_col_fields: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    (wr_en_in && addr_in == `PIXDATA_OFS) |=>
    (pix_addr_out[16:11] == $past(cpa_q[7:2]) && pix_addr_out[1] == $past(cpa_q[1])))
    else $error("column register fields misplaced");

  a_col_readback: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    (rd_en_in && addr_in == `CPA_OFS) |=>
    (rd_data_out == {8'h00, $past(cpa_q)}))
    else $error("column register read back wrong");

  a_row_fields: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    (wr_en_in && addr_in == `PIXDATA_OFS) |=>
    (pix_addr_out[10:5] == $past(row_q[8:3]) && pix_addr_out[4:2] == $past(row_q[2:0])))
    else $error("row register fields misplaced");

  a_row_readback: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    (rd_en_in && addr_in == `ROW_OFS) |=>
    (rd_data_out == {7'h00, $past(row_q)}))
    else $error("row register read back wrong");

  // Back-to-back pixel writes keep the strobe high
  a_pair_write: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    (wr_en_in && addr_in == `PIXDATA_OFS) |=>
    (pix_wr_out && pix_addr_out[0] == $past(cpa_q[0]) && pix_data_out == $past(wr_data_in[7:0])) ##1
    (pix_wr_out == $past(wr_en_in && addr_in == `PIXDATA_OFS)))
    else $error("pixel pair write wrong");

  a_cfg_load: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    (wr_en_in && addr_in == `ROW_OFS) |=>
    (row_q == $past(wr_data_in[8:0])))
    else $error("row register not loaded");

  a_upset_sticky: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    (upset_out && !(wr_en_in && addr_in == `STATUS_OFS && wr_data_in[`STATUS_UPSET_BIT])) |=>
    upset_out)
    else $error("upset flag lost without a clear");

  a_hold_limit: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    (state_q == ST_ADDR && s_reg.age >= 13'(HOLD_CYCLES) && !rec_ready_in) |=>
    (!rec_valid_out && !s_reg.hold_valid))
    else $error("stale hit not dropped");

  a_single_hit: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    (hit_valid_in && hit_ready_out) |=>
    (!hit_ready_out && s_reg.hold_valid))
    else $error("hit store accepted a second hit");

  a_state_onehot: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    $onehot(state_bits) && (rec_valid_out == (state_q != ST_IDLE)))
    else $error("emitter state corrupt");

  a_pixel_plain: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    !(wr_en_in && addr_in == `PIXDATA_OFS) |=>
    (pix_data_out == $past(pix_data_out) && !pix_wr_out))
    else $error("pixel data changed without a write");

endmodule : pixel_address_mapper

// ===== rtl/pam_cfg.svh
// Offsets, field positions, reset values and timing counts of the pixel address mapper
`ifndef PAM_CFG_SVH
`define PAM_CFG_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define PAM_ADDR_W 8
`define PAM_DATA_W 16
`define CPA_OFS 8'h01
`define ROW_OFS 8'h02
`define CTRL_OFS 8'h03
`define PIXDATA_OFS 8'h04
`define STATUS_OFS 8'h05
`define DROPS_OFS 8'h06

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CPA_COL_MSB 7
`define CPA_COL_LSB 2
`define CPA_REGION_BIT 1
`define CPA_PAIR_BIT 0
`define ROW_ROW_MSB 8
`define ROW_ROW_LSB 3
`define ROW_REGION_MSB 2
`define ROW_REGION_LSB 0
`define CTRL_EN_BIT 0
`define STATUS_BUSY_BIT 0
`define STATUS_HELD_BIT 1
`define STATUS_UPSET_BIT 2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CPA_RST 8'h00
`define ROW_RST 9'h000
`define CTRL_RST 1'b1

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 4
`define HIT_HOLD_NS 20000
`define HIT_HOLD_CYCLES (`HIT_HOLD_NS / `CLK_PERIOD_NS)
`define DEGLITCH_N 3

`endif

// ===== rtl/pam_pkg.sv
// Types shared by the pixel address mapper
package pam_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ADDR = 3'b010,
    ST_COUNT = 3'b100
  } rd_state_t;

  typedef struct packed {
    logic [15:0] rd_data;
    logic rec_valid;
    logic [15:0] rec_data;
    logic rec_last;
    logic hit_ready;
    logic hold_valid;
    logic [15:0] hold_addr;
    logic [15:0] hold_count;
    logic [12:0] age;
    logic [7:0] drop_cnt;
    logic [16:0] pix_addr;
    logic [7:0] pix_data;
    logic pix_wr;
    logic upset;
  } pam_state_t;

endpackage : pam_pkg

// ===== rtl/tmr_reg.sv
// Triple redundant register with majority vote and continuous correction
`timescale 1ns/1ps
module tmr_reg #(
  parameter int W = 8,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic load_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out,
  output logic upset_out
);
  typedef struct packed {
    logic [W-1:0] a;
    logic [W-1:0] b;
    logic [W-1:0] c;
  } tmr_t;

  tmr_t s_reg;
  tmr_t s_next;
  logic [W-1:0] vote;

  always_comb begin
    vote = (s_reg.a & s_reg.b) | (s_reg.a & s_reg.c) | (s_reg.b & s_reg.c);
    upset_out = (s_reg.a != s_reg.b) || (s_reg.a != s_reg.c);
    q_out = vote;
    // Rewriting all copies with the vote scrubs a single upset
    if (load_in) begin
      s_next = '{a: d_in, b: d_in, c: d_in};
    end else begin
      s_next = '{a: vote, b: vote, c: vote};
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      s_reg <= '{a: RST, b: RST, c: RST};
    end else begin
      s_reg <= s_next;
    end
  end

  a_scrub_copies: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    !load_in |=> (s_reg.a == $past(vote)) && (s_reg.b == s_reg.a) && (s_reg.c == s_reg.a))
    else $error("copies not corrected to vote");

endmodule : tmr_reg

// ===== rtl/deglitch.sv
// Deglitch filter: output follows input only after N equal samples
`timescale 1ns/1ps
module deglitch #(
  parameter int N = 3
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic sig_in,
  output logic sig_out
);
  typedef struct packed {
    logic [N-1:0] hist;
    logic out;
  } dg_t;

  dg_t s_reg;
  dg_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.hist = {s_reg.hist[N-2:0], sig_in};
    if (s_reg.hist == {N{1'b1}}) begin
      s_next.out = 1'b1;
    end else if (s_reg.hist == {N{1'b0}}) begin
      s_next.out = 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sig_out = s_reg.out;

  a_filter_steady: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    (s_reg.out != $past(s_reg.out)) |-> ($past(s_reg.hist) == {N{s_reg.out}}))
    else $error("filter output changed without steady input");

endmodule : deglitch

// ===== tb/rec_sink.sv
// Readout consumer model standing for the external controller
`timescale 1ns/1ps
module rec_sink (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic stall_in,
  input wire logic valid_in,
  input wire logic [15:0] data_in,
  input wire logic last_in,
  output logic ready_out = 1'b0,
  output logic got_out = 1'b0,
  output logic [15:0] word_out = 16'h0000,
  output logic last_out = 1'b0
);
  // Takes a word on a valid and ready edge, stalls as told
  always @(posedge mclk_in) begin
    got_out <= valid_in & ready_out & ~rst_in;
    word_out <= data_in;
    last_out <= last_in;
    ready_out <= ~stall_in & ~rst_in;
  end
endmodule : rec_sink

// ===== tb/tb.sv
// Self-checking bench of the pixel address mapper
`timescale 1ns/1ps
`include "pam_cfg.svh"
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin miscompares++; \
  $display("ERROR %0t got %h exp %h", $time, got, exp); end end
module tb;
  localparam int HOLD = 20;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic wr_en_in = 1'b0;
  logic rd_en_in = 1'b0;
  logic hit_valid_in = 1'b0;
  logic pause_in = 1'b0;
  logic stall = 1'b0;
  logic stall_all = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [15:0] wr_data_in = 16'h0000;
  logic [15:0] hit_count_in = 16'h0000;
  logic [5:0] hit_col_in = 6'h00;
  logic [5:0] hit_row_in = 6'h00;
  logic [3:0] hit_region_in = 4'h0;
  logic [15:0] rd_data_out, rec_data_out, sink_word, rv, w1, w2, w3;
  logic hit_ready_out, rec_valid_out, rec_last_out, rec_ready, pix_wr_out, upset_out, sink_got, sink_last;
  logic [16:0] pix_addr_out, e;
  logic [7:0] pix_data_out;
  logic [31:0] x;
  logic [16:0] exp_q[$];
  int miscompares = 0;
  int n_compared = 0;
  int seed = 32'hc089bfaa;

  always #2 mclk_in = ~mclk_in;
  always @(posedge mclk_in) stall <= stall_all || ($random(seed) % 4 == 0);

  pixel_address_mapper #(.HOLD_CYCLES(HOLD)) i_dut (.mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out),
    .hit_valid_in(hit_valid_in), .hit_col_in(hit_col_in), .hit_row_in(hit_row_in),
    .hit_region_in(hit_region_in), .hit_count_in(hit_count_in), .hit_ready_out(hit_ready_out),
    .pause_in(pause_in), .rec_valid_out(rec_valid_out), .rec_data_out(rec_data_out),
    .rec_last_out(rec_last_out), .rec_ready_in(rec_ready), .pix_addr_out(pix_addr_out),
    .pix_data_out(pix_data_out), .pix_wr_out(pix_wr_out), .upset_out(upset_out));
  rec_sink i_sink (.mclk_in(mclk_in), .rst_in(rst_in), .stall_in(stall), .valid_in(rec_valid_out),
    .data_in(rec_data_out), .last_in(rec_last_out), .ready_out(rec_ready), .got_out(sink_got),
    .word_out(sink_word), .last_out(sink_last));

  // ----------------------------------------
  // Bus and hit tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    wr_data_in <= d;
    wr_en_in <= 1'b1;
    @(posedge mclk_in);
    wr_en_in <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    rd_en_in <= 1'b1;
    @(posedge mclk_in);
    rd_en_in <= 1'b0;
    #1 rv = rd_data_out;
    `CHK(rv, d)
  endtask : rd_chk

  task automatic hit(input logic [31:0] h, input logic keep);
    @(posedge mclk_in);
    hit_valid_in <= 1'b1;
    {hit_count_in, hit_region_in, hit_row_in, hit_col_in} <= h;
    @(negedge mclk_in);
    for (int i = 0; i < 300 && hit_ready_out !== 1'b1; i++) @(negedge mclk_in);
    @(posedge mclk_in);
    hit_valid_in <= 1'b0;
    if (keep) begin
      exp_q.push_back({1'b0, h[5:0], h[11:6], h[15:12]});
      exp_q.push_back({1'b1, h[31:16]});
    end
  endtask : hit

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  always @(posedge mclk_in) if (sink_got === 1'b1) begin
    e = exp_q.size() ? exp_q.pop_front() : 17'h1ffff;
    `CHK({sink_last, sink_word}, e)
  end

  initial begin
    #200000;
    miscompares++;
    end_of_test;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge mclk_in);
    rst_in <= 1'b0;
    rd_chk(`CPA_OFS, 16'h0000);
    rd_chk(`ROW_OFS, 16'h0000);
    rd_chk(`CTRL_OFS, 16'h0001);
    rd_chk(8'h07, 16'h0000);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      w1 = 16'($random(seed));
      w2 = 16'($random(seed));
      w3 = 16'($random(seed));
      wr(`CPA_OFS, w1);
      wr(`ROW_OFS, w2);
      rd_chk(`CPA_OFS, {8'h00, w1[7:0]});
      rd_chk(`ROW_OFS, {7'h00, w2[8:0]});
      wr(`PIXDATA_OFS, w3);
      #1 `CHK(pix_wr_out, 1'b1)
      `CHK(pix_addr_out, {w1[7:2], w2[8:3], w2[2:0], w1[1], w1[0]})
      `CHK(pix_data_out, w3[7:0])
      rd_chk(`PIXDATA_OFS, {8'h00, w3[7:0]});
    end
    $display("test config addressing done");
    for (int i = 0; i < 24; i++) begin
      x = $random(seed);
      hit(x, 1'b1);
    end
    for (int i = 0; i < 400 && exp_q.size() != 0; i++) @(posedge mclk_in);
    `CHK(exp_q.size(), 0)
    rd_chk(`DROPS_OFS, 16'h0000);
    $display("test readout done");
    stall_all <= 1'b1;
    hit($random(seed), 1'b0);
    rd_chk(`STATUS_OFS, 16'h0003);
    repeat (HOLD + 10) @(posedge mclk_in);
    #1 `CHK(rec_valid_out, 1'b0)
    stall_all <= 1'b0;
    rd_chk(`DROPS_OFS, 16'h0001);
    wr(`DROPS_OFS, 16'h0000);
    rd_chk(`DROPS_OFS, 16'h0000);
    $display("test hit hold limit done");
    @(posedge mclk_in);
    pause_in <= 1'b1;
    repeat (8) @(posedge mclk_in);
    #1 `CHK(hit_ready_out, 1'b0)
    @(posedge mclk_in);
    pause_in <= 1'b0;
    repeat (8) @(posedge mclk_in);
    #1 `CHK(hit_ready_out, 1'b1)
    wr(`CTRL_OFS, 16'h0000);
    repeat (3) @(posedge mclk_in);
    #1 `CHK(hit_ready_out, 1'b0)
    wr(`CTRL_OFS, 16'h0001);
    #1 `CHK(upset_out, 1'b0)
    wr(`STATUS_OFS, 16'h0004);
    rd_chk(`STATUS_OFS, 16'h0000);
    $display("test control done");
    end_of_test;
  end
endmodule : tb
